// *** rx_fifo_pkg.sv ***
package rx_fifo_pkg;

  // Receive buffer geometry
  localparam int FIFO_DEPTH = 16;
  localparam int CNT_W      = 5;
  localparam int AFC_W      = 8;
  localparam int CMD_W      = 8;
  localparam int STATUS_W   = 16;
  localparam int THR_W      = 4;
  localparam int ADDR_W     = 8;
  localparam int DATA_W     = 32;

  // Register byte offsets
  localparam logic [ADDR_W-1:0] OFF_CTRL       = 8'h00;
  localparam logic [ADDR_W-1:0] OFF_SYNC       = 8'h04;
  localparam logic [ADDR_W-1:0] OFF_STATUS     = 8'h08;
  localparam logic [ADDR_W-1:0] OFF_IRQ_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFF_IRQ_CLEAR  = 8'h10;
  localparam logic [ADDR_W-1:0] OFF_IRQ_ENABLE = 8'h14;

  // Control register, bits [7:0]
  typedef struct packed {
    logic [THR_W-1:0] fill_threshold;
    logic             two_byte_sync;
    logic             afc_enable;
    logic             rx_enable;
    logic             fifo_enable;
  } ctrl_t;

  localparam logic [7:0] CTRL_RESET = 8'h1c;

  // Sync word: fixed first byte, programmable second byte
  localparam logic [7:0] SYNC_FIRST_BYTE = 8'h2d;
  localparam logic [7:0] SYNC_BYTE_RESET = 8'hd4;

  // Status word seen by APB and by the serial status command
  typedef struct packed {
    logic             fill_level_flag;
    logic             buffer_overflow_flag;
    logic             loading;
    logic [CNT_W-1:0] count;
    logic [AFC_W-1:0] afc_offset;
  } status_t;

  // Interrupt event bits (status, clear and enable share this layout)
  typedef struct packed {
    logic sync_found;
    logic overflow;
    logic fill_level;
  } irq_t;

  // Serial commands (first byte shifted in, MSB first)
  localparam logic [CMD_W-1:0] CMD_FIFO_READ   = 8'hb0;
  localparam logic [CMD_W-1:0] CMD_STATUS_READ = 8'h00;

  // Serial pins after synchronisation
  typedef struct packed {
    logic sck;
    logic cs_n;
    logic sdi;
    logic buffer_select_n;
  } serial_pins_t;

endpackage

// *** rx_bit_fifo.sv ***
`timescale 1ns/1ps
module rx_bit_fifo
  import rx_fifo_pkg::*;
#(
  parameter int DEPTH = FIFO_DEPTH
) (
  input  wire logic             clk,
  input  wire logic             rst_n,
  input  wire logic             flush,
  input  wire logic             push,
  input  wire logic             push_bit,
  input  wire logic             pop,
  output logic                  head_bit,
  output logic [CNT_W-1:0]      count,
  output logic                  overflow_evt
);

  typedef struct packed {
    logic [DEPTH-1:0] mem;
    logic [CNT_W-1:0] count;
  } fifo_state_t;

  localparam logic [CNT_W-1:0] ONE  = CNT_W'(1);
  localparam logic [CNT_W-1:0] FULL = CNT_W'(DEPTH);

  fifo_state_t s_q;
  fifo_state_t s_d;

  always_comb begin
    s_d          = s_q;
    overflow_evt = 1'b0;
    if (flush) begin
      s_d = '0;
    end else begin
      // Oldest bit sits at index 0; a pop shifts the rest down
      if (pop && s_q.count != '0) begin
        s_d.mem   = s_q.mem >> 1;
        s_d.count = s_q.count - ONE;
      end
      if (push) begin
        // Bits beyond capacity are dropped and reported
        if (s_d.count == FULL) begin
          overflow_evt = 1'b1;
        end else begin
          s_d.mem[s_d.count[CNT_W-2:0]] = push_bit;
          s_d.count                     = s_d.count + ONE;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign head_bit = s_q.mem[0];
  assign count    = s_q.count;

endmodule

// *** sync_word_matcher.sv ***
`timescale 1ns/1ps
module sync_word_matcher
  import rx_fifo_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_n,
  input  wire logic       clear,
  input  wire logic       bit_valid,
  input  wire logic       bit_in,
  input  wire logic [7:0] sync_byte,
  input  wire logic       two_byte,
  output logic            match
);

  typedef struct packed {
    logic [15:0] shreg;
    logic        match;
  } match_state_t;

  match_state_t s_q;
  match_state_t s_d;

  function automatic logic word_hit(input logic [15:0] w, input logic [7:0] b,
                                    input logic two);
    word_hit = (w[7:0] == b) && (!two || w[15:8] == SYNC_FIRST_BYTE);
  endfunction

  always_comb begin
    s_d       = s_q;
    s_d.match = 1'b0;
    if (clear) begin
      s_d = '0;
    end else if (bit_valid) begin
      s_d.shreg = {s_q.shreg[14:0], bit_in};
      s_d.match = word_hit(s_d.shreg, sync_byte, two_byte);
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      s_q <= '0;
    end else begin
      s_q <= s_d;
    end
  end

  assign match = s_q.match;

endmodule

// *** rx_fifo_serial_readout.sv ***
// Behaviour
// - Each received bit is shifted into a sixteen-bit first-in first-out buffer.
// - Loading starts only once valid-data indicator and sync match agree.
// - Programmable bit threshold; fill flag and interrupt rise when reached.
// - Buffer select low routes buffer head to serial output, one bit per clock.
// - A serial read command also returns stored buffer bits.
// - Sync byte is programmable; optional fixed first byte makes a two-byte word.
// - The status word carries the measured frequency offset.
// - Overflow flag on too many bits, alongside fill flag; status read clears it.
// - Fill flag holds until count falls below threshold or receiver/buffer switched off.
//
// Chosen here: the address map and the APB register port.
`timescale 1ns/1ps
module rx_fifo_serial_readout
  import rx_fifo_pkg::*;
(
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [DATA_W-1:0] pwdata,
  output logic      [DATA_W-1:0] prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              rx_bit,
  input  wire logic              rx_bit_valid,
  input  wire logic              valid_data_indicator,
  input  wire logic [AFC_W-1:0]  afc_offset,
  input  wire logic              sck,
  input  wire logic              cs_n,
  input  wire logic              sdi,
  input  wire logic              buffer_select_n,
  output logic                   sdo,
  output logic                   sdo_oe,
  output logic                   fill_level_irq_n,
  output logic                   afc_enable,
  output logic                   irq
);

  typedef enum logic [2:0] {
    SER_IDLE,
    SER_CMD,
    SER_FIFO,
    SER_STATUS,
    SER_DONE
  } ser_state_t;

  typedef struct packed {
    serial_pins_t            pins_meta;
    serial_pins_t            pins_sync;
    logic                    sck_prev;
    ser_state_t              ser;
    logic [CMD_W-1:0]        cmd_sh;
    logic [2:0]              cmd_cnt;
    logic [STATUS_W-1:0]     status_sh;
    logic                    sdo;
    logic                    sdo_oe;
    ctrl_t                   ctrl;
    logic [7:0]              sync_byte;
    logic                    loading;
    logic                    fill;
    logic                    overflow;
    irq_t                    irq_st;
    irq_t                    irq_en;
    logic [DATA_W-1:0]       prdata;
  } state_t;

  localparam logic [2:0] CMD_LAST = 3'(CMD_W - 1);

  state_t s_q;
  state_t s_d;

  logic             head_bit;
  logic [CNT_W-1:0] fifo_count;
  logic             overflow_evt;
  logic             sync_match;
  logic             fifo_push;
  logic             fifo_pop;
  logic             fifo_flush;

  function automatic logic addr_mapped(input logic [ADDR_W-1:0] a);
    if (a == OFF_CTRL) begin
      addr_mapped = 1'b1;
    end else if (a == OFF_SYNC) begin
      addr_mapped = 1'b1;
    end else if (a == OFF_STATUS) begin
      addr_mapped = 1'b1;
    end else if (a == OFF_IRQ_STATUS) begin
      addr_mapped = 1'b1;
    end else if (a == OFF_IRQ_CLEAR) begin
      addr_mapped = 1'b1;
    end else if (a == OFF_IRQ_ENABLE) begin
      addr_mapped = 1'b1;
    end else begin
      addr_mapped = 1'b0;
    end
  endfunction

  function automatic status_t build_status(input state_t st, input logic [CNT_W-1:0] cnt,
                                           input logic [AFC_W-1:0] afc);
    build_status.fill_level_flag      = st.fill;
    build_status.buffer_overflow_flag = st.overflow;
    build_status.loading              = st.loading;
    build_status.count                = cnt;
    build_status.afc_offset           = afc;
  endfunction

  status_t status_now;
  logic    apb_setup;
  logic    apb_wr;
  logic    apb_rd;
  logic    sck_rise;
  logic    direct_mode;
  logic    status_clear;
  irq_t    irq_events;
  irq_t    irq_clr;

  assign status_now  = build_status(s_q, fifo_count, afc_offset);
  assign apb_setup   = psel && !penable;
  assign apb_wr      = psel && penable && pwrite && addr_mapped(paddr);
  assign apb_rd      = psel && penable && !pwrite && addr_mapped(paddr);
  assign sck_rise    = s_q.pins_sync.sck && !s_q.sck_prev;
  // Select line only acts while no command frame is open
  assign direct_mode = !s_q.pins_sync.buffer_select_n && s_q.pins_sync.cs_n;

  // pop per serial clock in direct mode; pop in command read
  assign fifo_pop   = sck_rise && (direct_mode || s_q.ser == SER_FIFO);
  // switching off receiver or buffer empties it
  assign fifo_flush = !s_q.ctrl.fifo_enable || !s_q.ctrl.rx_enable;
  assign fifo_push  = s_q.loading && rx_bit_valid && !fifo_flush;

  always_comb begin
    s_d          = s_q;
    status_clear = 1'b0;
    irq_events   = '0;
    irq_clr      = '0;

    // Pin synchronisers: the first stage feeds only the second
    s_d.pins_meta.sck             = sck;
    s_d.pins_meta.cs_n            = cs_n;
    s_d.pins_meta.sdi             = sdi;
    s_d.pins_meta.buffer_select_n = buffer_select_n;
    s_d.pins_sync                 = s_q.pins_meta;
    s_d.sck_prev                  = s_q.pins_sync.sck;

    // begin loading once data valid and sync seen together
    if (fifo_flush) begin
      s_d.loading = 1'b0;
    end else if (valid_data_indicator && sync_match) begin
      s_d.loading = 1'b1;
    end

    // Serial command engine
    if (s_q.pins_sync.cs_n) begin
      s_d.ser     = SER_IDLE;
      s_d.cmd_cnt = '0;
    end else begin
      case (s_q.ser)
        SER_IDLE: begin
          s_d.ser     = SER_CMD;
          s_d.cmd_cnt = '0;
        end
        SER_CMD: begin
          if (sck_rise) begin
            s_d.cmd_sh  = {s_q.cmd_sh[CMD_W-2:0], s_q.pins_sync.sdi};
            s_d.cmd_cnt = s_q.cmd_cnt + 3'(1);
            if (s_q.cmd_cnt == CMD_LAST) begin
              if (s_d.cmd_sh == CMD_FIFO_READ) begin
                s_d.ser = SER_FIFO;
              end else if (s_d.cmd_sh == CMD_STATUS_READ) begin
                s_d.ser       = SER_STATUS;
                s_d.status_sh = status_now;
                status_clear  = 1'b1;
              end else begin
                s_d.ser = SER_DONE;
              end
            end
          end
        end
        SER_STATUS: begin
          // Advance on the rise that takes the shown bit, as the buffer readout does
          if (sck_rise) begin
            s_d.status_sh = {s_q.status_sh[STATUS_W-2:0], 1'b0};
          end
        end
        SER_FIFO: begin
          s_d.ser = SER_FIFO;
        end
        default: begin
          s_d.ser = SER_DONE;
        end
      endcase
    end

    if (direct_mode || s_d.ser == SER_FIFO) begin
      s_d.sdo = head_bit;
    end else if (s_d.ser == SER_STATUS) begin
      s_d.sdo = s_d.status_sh[STATUS_W-1];
    end else begin
      s_d.sdo = 1'b0;
    end
    s_d.sdo_oe = !s_q.pins_sync.cs_n || !s_q.pins_sync.buffer_select_n;

    // flag when stored count reaches threshold; drops as bits read
    s_d.fill = !fifo_flush && (fifo_count != '0)
               && (fifo_count >= CNT_W'(s_q.ctrl.fill_threshold));

    // APB register access
    if (apb_wr) begin
      if (paddr == OFF_CTRL) begin
        s_d.ctrl = ctrl_t'(pwdata[7:0]);
      end else if (paddr == OFF_SYNC) begin
        s_d.sync_byte = pwdata[7:0];
      end else if (paddr == OFF_IRQ_CLEAR) begin
        irq_clr = irq_t'(pwdata[2:0]);
      end else if (paddr == OFF_IRQ_ENABLE) begin
        s_d.irq_en = irq_t'(pwdata[2:0]);
      end
    end
    if (apb_rd && paddr == OFF_STATUS) begin
      status_clear = 1'b1;
    end
    if (apb_setup) begin
      if (paddr == OFF_CTRL) begin
        s_d.prdata = DATA_W'(s_q.ctrl);
      end else if (paddr == OFF_SYNC) begin
        s_d.prdata = DATA_W'({SYNC_FIRST_BYTE, s_q.sync_byte});
      end else if (paddr == OFF_STATUS) begin
        s_d.prdata = DATA_W'(status_now);
      end else if (paddr == OFF_IRQ_STATUS) begin
        s_d.prdata = DATA_W'(s_q.irq_st);
      end else if (paddr == OFF_IRQ_ENABLE) begin
        s_d.prdata = DATA_W'(s_q.irq_en);
      end else begin
        s_d.prdata = '0;
      end
    end

    // overflow set wins over status-read clear
    if (overflow_evt) begin
      s_d.overflow = 1'b1;
    end else if (status_clear) begin
      s_d.overflow = 1'b0;
    end

    irq_events.fill_level = s_d.fill && !s_q.fill;
    irq_events.overflow   = overflow_evt;
    irq_events.sync_found = sync_match && !s_q.loading;
    // Sticky events: a new event in the clear cycle is kept
    s_d.irq_st = (s_q.irq_st & ~irq_clr) | irq_events;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s_q                 <= '0;
      s_q.pins_meta       <= '1;
      s_q.pins_sync       <= '1;
      // Serial clock idles low; a high reset value would fake a first edge
      s_q.pins_meta.sck   <= 1'b0;
      s_q.pins_sync.sck   <= 1'b0;
      s_q.ser             <= SER_IDLE;
      s_q.ctrl            <= ctrl_t'(CTRL_RESET);
      s_q.sync_byte       <= SYNC_BYTE_RESET;
    end else begin
      s_q <= s_d;
    end
  end

  rx_bit_fifo #(
    .DEPTH        (FIFO_DEPTH)
  ) rx_bit_fifo_i (
    .clk          (pclk),
    .rst_n        (presetn),
    .flush        (fifo_flush),
    .push         (fifo_push),
    .push_bit     (rx_bit),
    .pop          (fifo_pop),
    .head_bit     (head_bit),
    .count        (fifo_count),
    .overflow_evt (overflow_evt)
  );

  // sync recognizer, one or two bytes
  sync_word_matcher sync_word_matcher_i (
    .clk       (pclk),
    .rst_n     (presetn),
    .clear     (fifo_flush || s_q.loading),
    .bit_valid (rx_bit_valid),
    .bit_in    (rx_bit),
    .sync_byte (s_q.sync_byte),
    .two_byte  (s_q.ctrl.two_byte_sync),
    .match     (sync_match)
  );

  // Zero-wait slave: data captured in setup, answered in first access cycle
  assign pready           = 1'b1;
  assign pslverr          = psel && penable && !addr_mapped(paddr);
  assign prdata           = s_q.prdata;
  assign sdo              = s_q.sdo;
  assign sdo_oe           = s_q.sdo_oe;
  assign fill_level_irq_n = !s_q.fill;
  assign afc_enable       = s_q.ctrl.afc_enable;
  assign irq              = |(s_q.irq_st & s_q.irq_en);

endmodule

// *** rx_fifo_serial_readout_asserts.sv ***
`timescale 1ns/1ps
module rx_fifo_serial_readout_asserts
  import rx_fifo_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [DATA_W-1:0] pwdata,
  input wire logic [DATA_W-1:0] prdata,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              rx_bit,
  input wire logic              rx_bit_valid,
  input wire logic              valid_data_indicator,
  input wire logic [AFC_W-1:0]  afc_offset,
  input wire logic              sck,
  input wire logic              cs_n,
  input wire logic              sdi,
  input wire logic              buffer_select_n,
  input wire logic              sdo,
  input wire logic              sdo_oe,
  input wire logic              fill_level_irq_n,
  input wire logic              afc_enable,
  input wire logic              irq
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  logic acc;
  assign acc = psel && penable;

  chk_zero_wait: assert property (acc |-> pready)
    else $error("access phase without ready");
  chk_unmapped_err: assert property (acc && paddr > OFF_IRQ_ENABLE |-> pslverr)
    else $error("unmapped access not refused");
  chk_upper_zero: assert property (acc && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("upper read bits not zero");
  chk_sync_fixed: assert property (
    acc && !pwrite && paddr == OFF_SYNC |-> prdata[15:8] == SYNC_FIRST_BYTE)
    else $error("fixed sync byte wrong");
  chk_afc_follow: assert property (
    acc && pwrite && paddr == OFF_CTRL |=> afc_enable == $past(pwdata[2]))
    else $error("frequency control enable not updated");
  chk_off_release: assert property (
    acc && pwrite && paddr == OFF_CTRL && !pwdata[0] |-> ##[1:4] fill_level_irq_n)
    else $error("fill flag kept with buffer off");
  chk_mask_irq: assert property (
    acc && pwrite && paddr == OFF_IRQ_ENABLE && pwdata[2:0] == 3'b000 |=> !irq)
    else $error("masked interrupt still high");
  chk_oe_idle: assert property ((cs_n && buffer_select_n) [*5] |-> !sdo_oe)
    else $error("serial output driven while idle");
  chk_oe_direct: assert property ($fell(buffer_select_n) |-> ##[1:5] sdo_oe)
    else $error("direct mode does not drive output");
endmodule

bind rx_fifo_serial_readout rx_fifo_serial_readout_asserts rx_fifo_serial_readout_asserts_i (
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
  .rx_bit, .rx_bit_valid, .valid_data_indicator, .afc_offset, .sck, .cs_n, .sdi,
  .buffer_select_n, .sdo, .sdo_oe, .fill_level_irq_n, .afc_enable, .irq);

// *** serial_host.sv ***
`timescale 1ns/1ps
module serial_host (
  input  wire logic pclk,
  input  wire logic sdo,
  output logic      sck,
  output logic      cs_n,
  output logic      sdi,
  output logic      buffer_select_n
);
  // Pins idle high except the clock, which stands still low between frames
  initial begin
    sck             = 1'b0;
    cs_n            = 1'b1;
    sdi             = 1'b1;
    buffer_select_n = 1'b1;
  end

  // phases of 8 reference cycles, far below a quarter of the rate
  task automatic xfer(input logic o, output logic i);
    @(posedge pclk);
    sdi <= o;
    repeat (6) @(posedge pclk);
    // Output read half a cycle before the rise, clear of its launch edge
    @(negedge pclk);
    i = sdo;
    @(posedge pclk);
    sck <= 1'b1;
    repeat (8) @(posedge pclk);
    sck <= 1'b0;
  endtask

  // direct select or read command, bits sampled before each rise
  task automatic frame(input logic direct, input logic [7:0] cmd, input int n,
                       output logic [15:0] got);
    logic b;
    got = 16'h0000;
    @(posedge pclk);
    if (direct) buffer_select_n <= 1'b0;
    else cs_n <= 1'b0;
    repeat (8) @(posedge pclk);
    if (!direct) for (int k = 7; k >= 0; k--) xfer(cmd[k], b);
    for (int k = 0; k < n; k++) begin
      xfer(1'b1, b);
      got = {got[14:0], b};
    end
    @(posedge pclk);
    cs_n            <= 1'b1;
    buffer_select_n <= 1'b1;
    sdi             <= 1'b1;
  endtask
endmodule

// *** tb_rx_fifo_serial_readout.sv ***
`timescale 1ns/1ps
module tb_rx_fifo_serial_readout
  import rx_fifo_pkg::*;
;
  logic              pclk, presetn, psel, penable, pwrite, pready, pslverr, se;
  logic [ADDR_W-1:0] paddr;
  logic [DATA_W-1:0] pwdata, prdata, rd;
  logic              rx_bit, rx_bit_valid, valid_data_indicator, sdo, sdo_oe;
  logic [AFC_W-1:0]  afc_offset;
  logic              sck, cs_n, sdi, buffer_select_n, fill_level_irq_n, afc_enable, irq;
  logic [15:0]       got, poll;
  int                err_count, comparisons, cyc, nb;

  rx_fifo_serial_readout rx_fifo_serial_readout_i (.pclk, .presetn, .psel, .penable,
    .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .rx_bit, .rx_bit_valid,
    .valid_data_indicator, .afc_offset, .sck, .cs_n, .sdi, .buffer_select_n, .sdo,
    .sdo_oe, .fill_level_irq_n, .afc_enable, .irq);
  serial_host serial_host_i (.pclk, .sdo, .sck, .cs_n, .sdi, .buffer_select_n);

  initial pclk = 1'b0;
  always #5 pclk = ~pclk;

  task automatic stop_test();
    $display("err_count=%0d comparisons=%0d", err_count, comparisons);
    if (err_count == 0 && comparisons > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      stop_test();
    end
  end

  task automatic cmp(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      err_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask

  task automatic apb(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(negedge pclk);
  endtask

  // Bits are sent MSB first, one valid pulse every other cycle
  task automatic rx_send(input logic [23:0] d, input int n);
    for (int k = n - 1; k >= 0; k--) begin
      @(posedge pclk);
      rx_bit       <= d[k];
      rx_bit_valid <= 1'b1;
      @(posedge pclk);
      rx_bit_valid <= 1'b0;
    end
    repeat (6) @(posedge pclk);
    @(negedge pclk);
  endtask

  initial begin
    {psel, penable, pwrite, rx_bit, rx_bit_valid, valid_data_indicator} = '0;
    {paddr, pwdata, cyc, err_count, comparisons, nb, poll} = '0;
    afc_offset = 8'h3c;
    presetn    = 1'b0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_CTRL, 32'h0);
    cmp(rd, 32'h0000_001c);
    apb(1'b0, 8'h20, 32'h0);
    cmp({rd[31:1], se}, 32'h0000_0001);
    apb(1'b1, OFF_SYNC, 32'h0000_005a);
    apb(1'b0, OFF_SYNC, 32'h0);
    cmp(rd, 32'h0000_2d5a);
    apb(1'b1, OFF_IRQ_ENABLE, 32'h0000_0007);
    apb(1'b1, OFF_CTRL, 32'h0000_008f);
    rx_send(24'haa_2d5a, 24);
    rx_send(24'hff, 8);
    apb(1'b0, OFF_STATUS, 32'h0);
    cmp(rd & 32'h0000_3f00, 32'h0);
    @(posedge pclk);
    valid_data_indicator <= 1'b1;
    rx_send(24'haa_2d5a, 24);
    rx_send(24'h2e, 7);
    cmp(32'(fill_level_irq_n), 32'h1);
    rx_send(24'h0, 1);
    cmp(32'(fill_level_irq_n), 32'h0);
    apb(1'b0, OFF_STATUS, 32'h0);
    cmp(rd, 32'h0000_a83c);
    rx_send(24'h1a5, 9);
    apb(1'b0, OFF_STATUS, 32'h0);
    cmp(rd, 32'h0000_f03c);
    apb(1'b0, OFF_STATUS, 32'h0);
    cmp(rd, 32'h0000_b03c);
    apb(1'b0, OFF_IRQ_STATUS, 32'h0);
    cmp(rd, 32'h0000_0007);
    apb(1'b1, OFF_IRQ_ENABLE, 32'h0);
    cmp(32'(irq), 32'h0);
    apb(1'b1, OFF_IRQ_ENABLE, 32'h0000_0007);
    cmp(32'(irq), 32'h1);
    apb(1'b1, OFF_IRQ_CLEAR, 32'h0000_0007);
    apb(1'b0, OFF_IRQ_STATUS, 32'h0);
    cmp({rd[31:1], irq}, 32'h0);
    serial_host_i.frame(1'b1, 8'h00, 16, got);
    cmp(32'(got), 32'h0000_5cd2);
    repeat (8) @(negedge pclk);
    cmp(32'(fill_level_irq_n), 32'h1);
    apb(1'b1, OFF_CTRL, 32'h0000_001f);
    rx_send(24'h3, 3);
    while (nb < 8 && fill_level_irq_n === 1'b0) begin
      serial_host_i.frame(1'b1, 8'h00, 1, got);
      poll = {poll[14:0], got[0]};
      nb++;
      repeat (8) @(negedge pclk);
    end
    cmp({poll, 16'(nb)}, 32'h0003_0003);
    rx_send(24'h5, 3);
    serial_host_i.frame(1'b0, CMD_FIFO_READ, 3, got);
    cmp(32'(got), 32'h5);
    apb(1'b1, OFF_CTRL, 32'h0000_001b);
    cmp(32'(afc_enable), 32'h0);
    @(posedge pclk);
    afc_offset <= 8'hc3;
    apb(1'b0, OFF_STATUS, 32'h0);
    cmp(rd & 32'h0000_00ff, 32'h0000_00c3);
    rx_send(24'h3, 2);
    cmp(32'(fill_level_irq_n), 32'h0);
    apb(1'b1, OFF_CTRL, 32'h0000_0018);
    repeat (3) @(negedge pclk);
    cmp(32'(fill_level_irq_n), 32'h1);
    apb(1'b0, OFF_STATUS, 32'h0);
    cmp(rd & 32'h0000_ff00, 32'h0);
    apb(1'b1, OFF_CTRL, 32'h0000_0007);
    rx_send(24'h5a, 8);
    rx_send(24'h1, 1);
    serial_host_i.frame(1'b0, CMD_STATUS_READ, 16, got);
    cmp(32'(got), 32'h0000_a1c3);
    stop_test();
  end
endmodule
